// ---- sps_pkg.sv ----
`default_nettype none
package sps_pkg;
  // Clock rate and default line rate
  localparam int CLK_HZ = 125_000_000;
  localparam int DEFAULT_BAUD = 9600;

  // Register offsets (byte addresses on the plain port)
  localparam logic [2:0] RX_STATUS_OFS = 3'h0;
  localparam logic [2:0] RX_BUFFER_OFS = 3'h2;
  localparam logic [2:0] TX_STATUS_OFS = 3'h4;
  localparam logic [2:0] TX_BUFFER_OFS = 3'h6;

  // Field positions
  localparam int READER_RUN_BIT = 0;
  localparam int BREAK_CTL_BIT = 0;
  localparam int IE_BIT = 6;
  localparam int DONE_BIT = 7;
  localparam int SWITCH_LSB = 8;
  localparam int OVERRUN_BIT = 12;
  localparam int BREAK_BIT = 13;
  localparam int PARITY_BIT = 14;
  localparam int ERROR_BIT = 15;
  localparam int MODEM_BIT = 15;
  localparam int CHAR_BITS = 7;

  // Values after reset
  localparam logic RX_DONE_RST = 1'b0;
  localparam logic TX_DONE_RST = 1'b1;
  localparam logic IE_RST = 1'b0;
  localparam logic LINE_IDLE = 1'b1;

  typedef enum logic [2:0]
  {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h3,
    RX_PARITY = 3'h2,
    RX_STOP = 3'h6
  } sps_rx_state_t;
endpackage
`default_nettype wire

// ---- sps_serial_port.sv ----
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: Receiver status bit 6 is read/write interrupt enable, bit 7 read-only done.
// RULE2: Receiver status bits 8 to 11 show the four option switches.
// RULE3: Receiver status bits 12, 13, 14 report overrun, break, parity error.
// RULE4: Receiver status bit 15 is OR of the three error bits.
// RULE5: A completed character goes to the receive buffer and sets done.
// RULE6: Only the low seven bits of both data buffers are valid.
// RULE7: Receive done with enable on requests the receive interrupt.
// RULE8: Any receive error sets error and done, interrupting if enabled.
// RULE9: New character before previous was read flags overrun; new data stays.
// RULE10: A line held continuously in break sets break detected.
// RULE11: Parity failure with parity checking selected sets parity error.
// RULE12: Write-only reader-run bit drives a line letting the reader read one character.
// RULE13: Reader-run clears itself whenever a character is received.
// RULE14: Software must set reader-run again for every character.
// RULE15: System reset or reset instruction clears receive done.
// RULE16: Enabling with done clear gives no interrupt; with done set, one at once.
// RULE17: Transmitter status bit 6 is read/write enable, bit 7 read-only done.
// RULE18: Transmitter status bit 15 shows modem ready and never interrupts.
// RULE19: Writing transmit buffer starts shifting; done sets after the whole stream.
// RULE20: Transmit done with enable on requests the transmit interrupt.
// RULE21: Write-only break control holds the serial output in break while set.
// RULE22: System reset or reset instruction sets transmit done.
// RULE23: A switch off reads as one, on reads as zero, in both registers.
// RULE24: Writing the transmit buffer clears done until the character is shifted out.
// RULE25: Reading the receive buffer clears receive done and the error bits.
module sps_serial_port
  import sps_pkg::*;
#(
  parameter int BAUD = DEFAULT_BAUD
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Reset instruction, same clock
  input wire logic bus_init,
  // Serial line and reader control
  input wire logic serial_in,
  output logic serial_out,
  output logic reader_run,
  input wire logic modem_ready,
  // Option switches, high means switch on
  input wire logic [3:0] board_option_switches_on,
  input wire logic seven_bit_on,
  input wire logic parity_on,
  // Interrupt requests
  output logic rx_int_req,
  output logic tx_int_req
);

  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam logic [19:0] BIT_LOAD = 20'(BIT_CYCLES - 1);
  localparam logic [19:0] HALF_LOAD = 20'(BIT_CYCLES / 2 - 1);

  // Two-stage synchronisers for every pin input
  logic [7:0] pin_meta_q;
  logic [7:0] pin_sync_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_q <= 8'h01;
      pin_sync_q <= 8'h01;
    end
    else
    begin
      pin_meta_q <= {parity_on, seven_bit_on, modem_ready, board_option_switches_on,
                     serial_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic rx_line;
  logic modem_ok;
  logic parity_en;
  logic seven_bits;
  logic [3:0] switch_bits;
  assign rx_line = pin_sync_q[0];
  // Switch off gives one
  // RULE23: off reads one
  assign switch_bits = ~pin_sync_q[4:1];
  assign modem_ok = pin_sync_q[5];
  assign seven_bits = pin_sync_q[6];
  assign parity_en = pin_sync_q[7];

  logic [3:0] last_data_idx;
  assign last_data_idx = seven_bits ? 4'h6 : 4'h7;

  // Register access decode
  logic wr_rx_status;
  logic wr_tx_status;
  logic wr_tx_buffer;
  logic rd_rx_buffer;
  assign wr_rx_status = reg_wr && (reg_addr == RX_STATUS_OFS);
  assign wr_tx_status = reg_wr && (reg_addr == TX_STATUS_OFS);
  assign wr_tx_buffer = reg_wr && (reg_addr == TX_BUFFER_OFS);
  assign rd_rx_buffer = reg_rd && (reg_addr == RX_BUFFER_OFS);

  // Receiver framing
  sps_rx_state_t rx_state_q;
  logic [19:0] rx_bcnt_q;
  logic [3:0] rx_idx_q;
  logic [7:0] rx_shift_q;
  logic rx_par_q;
  logic rx_mark_q;
  logic rx_frame_done_q;
  logic rx_brk_hit_q;
  logic rx_par_hit_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state_q <= RX_IDLE;
      rx_bcnt_q <= 20'h0;
      rx_idx_q <= 4'h0;
      rx_shift_q <= 8'h0;
      rx_par_q <= 1'b0;
      rx_mark_q <= 1'b0;
      rx_frame_done_q <= 1'b0;
      rx_brk_hit_q <= 1'b0;
      rx_par_hit_q <= 1'b0;
    end
    else
    begin
      rx_frame_done_q <= 1'b0;
      if (rx_state_q != RX_IDLE && rx_bcnt_q != 20'h0)
      begin
        rx_bcnt_q <= rx_bcnt_q - 20'h1;
      end
      else
      begin
        case (rx_state_q)
          RX_IDLE:
          begin
            if (!rx_line)
            begin
              rx_state_q <= RX_START;
              rx_bcnt_q <= HALF_LOAD;
            end
          end
          RX_START:
          begin
            // Glitch shorter than half a bit is dropped
            rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
            rx_bcnt_q <= BIT_LOAD;
            rx_idx_q <= 4'h0;
            rx_par_q <= 1'b0;
            rx_mark_q <= 1'b0;
            rx_shift_q <= 8'h0;
          end
          RX_DATA:
          begin
            rx_shift_q[rx_idx_q[2:0]] <= rx_line;
            rx_par_q <= rx_par_q ^ rx_line;
            rx_mark_q <= rx_mark_q | rx_line;
            rx_idx_q <= rx_idx_q + 4'h1;
            rx_bcnt_q <= BIT_LOAD;
            if (rx_idx_q == last_data_idx)
            begin
              rx_state_q <= parity_en ? RX_PARITY : RX_STOP;
            end
          end
          RX_PARITY:
          begin
            rx_par_q <= rx_par_q ^ rx_line;
            rx_mark_q <= rx_mark_q | rx_line;
            rx_bcnt_q <= BIT_LOAD;
            rx_state_q <= RX_STOP;
          end
          RX_STOP:
          begin
            rx_frame_done_q <= 1'b1;
            // RULE10: all-space frame
            rx_brk_hit_q <= !rx_line && !rx_mark_q;
            // RULE11: even parity check
            rx_par_hit_q <= parity_en && rx_par_q;
            rx_state_q <= RX_IDLE;
          end
          default:
          begin
            rx_state_q <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // Receive buffer and flags
  logic [6:0] rx_buf_q;
  logic rx_done_q;
  logic rx_ie_q;
  logic rx_ovr_q;
  logic rx_brk_q;
  logic rx_perr_q;
  logic reader_run_q;
  logic rx_error;
  // RULE4: summary error
  assign rx_error = rx_ovr_q | rx_brk_q | rx_perr_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_buf_q <= 7'h0;
    end
    else if (rx_frame_done_q)
    begin
      // RULE5: store character
      // RULE6: seven bits kept
      rx_buf_q <= rx_shift_q[CHAR_BITS-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_done_q <= RX_DONE_RST;
    end
    else if (bus_init)
    begin
      // RULE15: init clears done
      rx_done_q <= RX_DONE_RST;
    end
    else if (rx_frame_done_q)
    begin
      // RULE8: errors set done too
      rx_done_q <= 1'b1;
    end
    else if (rd_rx_buffer)
    begin
      // RULE25: read clears done
      rx_done_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_ovr_q <= 1'b0;
      rx_brk_q <= 1'b0;
      rx_perr_q <= 1'b0;
    end
    else if (bus_init)
    begin
      rx_ovr_q <= 1'b0;
      rx_brk_q <= 1'b0;
      rx_perr_q <= 1'b0;
    end
    else if (rx_frame_done_q)
    begin
      // RULE9: unread character overrun
      rx_ovr_q <= (rx_done_q && !rd_rx_buffer) | (rx_ovr_q && !rd_rx_buffer);
      rx_brk_q <= rx_brk_hit_q | (rx_brk_q && !rd_rx_buffer);
      rx_perr_q <= rx_par_hit_q | (rx_perr_q && !rd_rx_buffer);
    end
    else if (rd_rx_buffer)
    begin
      // RULE25: read clears errors
      rx_ovr_q <= 1'b0;
      rx_brk_q <= 1'b0;
      rx_perr_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reader_run_q <= 1'b0;
    end
    else if (bus_init)
    begin
      reader_run_q <= 1'b0;
    end
    else if (wr_rx_status)
    begin
      // RULE12: reader-run set by write
      reader_run_q <= reg_wdata[READER_RUN_BIT];
    end
    else if (rx_frame_done_q)
    begin
      // RULE13: auto clear on receipt
      reader_run_q <= 1'b0;
    end
  end

  // Enables and break control
  logic tx_ie_q;
  logic break_ctl_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_ie_q <= IE_RST;
      tx_ie_q <= IE_RST;
      break_ctl_q <= 1'b0;
    end
    else if (bus_init)
    begin
      rx_ie_q <= IE_RST;
      tx_ie_q <= IE_RST;
      break_ctl_q <= 1'b0;
    end
    else
    begin
      if (wr_rx_status)
      begin
        // RULE1: receive enable
        rx_ie_q <= reg_wdata[IE_BIT];
      end
      if (wr_tx_status)
      begin
        // RULE17: transmit enable
        tx_ie_q <= reg_wdata[IE_BIT];
        // RULE21: break control
        break_ctl_q <= reg_wdata[BREAK_CTL_BIT];
      end
    end
  end

  // Transmitter; writes while shifting are ignored to keep frames intact
  logic tx_busy_q;
  logic tx_done_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_left_q;
  logic [19:0] tx_bcnt_q;
  logic tx_line_q;
  logic [3:0] stop_idx;
  // Frame position of the stop bit: start, data, optional parity
  assign stop_idx = last_data_idx + (parity_en ? 4'h3 : 4'h2);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_busy_q <= 1'b0;
      tx_shift_q <= 11'h7ff;
      tx_left_q <= 4'h0;
      tx_bcnt_q <= 20'h0;
    end
    else if (bus_init)
    begin
      tx_busy_q <= 1'b0;
      tx_shift_q <= 11'h7ff;
      tx_left_q <= 4'h0;
    end
    else if (!tx_busy_q)
    begin
      if (wr_tx_buffer)
      begin
        // RULE19: start shifting
        // RULE6: bit 7 and parity sent as space
        tx_busy_q <= 1'b1;
        tx_shift_q <= (11'h7ff << stop_idx) | {3'h0, reg_wdata[CHAR_BITS-1:0], 1'b0};
        tx_left_q <= stop_idx + 4'h1;
        tx_bcnt_q <= BIT_LOAD;
      end
    end
    else if (tx_bcnt_q != 20'h0)
    begin
      tx_bcnt_q <= tx_bcnt_q - 20'h1;
    end
    else
    begin
      tx_shift_q <= {1'b1, tx_shift_q[10:1]};
      tx_left_q <= tx_left_q - 4'h1;
      tx_bcnt_q <= BIT_LOAD;
      if (tx_left_q == 4'h1)
      begin
        tx_busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_done_q <= TX_DONE_RST;
    end
    else if (bus_init)
    begin
      // RULE22: init sets done
      tx_done_q <= TX_DONE_RST;
    end
    else if (wr_tx_buffer && !tx_busy_q)
    begin
      // RULE24: cleared while shifting
      tx_done_q <= 1'b0;
    end
    else if (tx_busy_q && tx_bcnt_q == 20'h0 && tx_left_q == 4'h1)
    begin
      // RULE19: done after stop bit
      tx_done_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_line_q <= LINE_IDLE;
    end
    else
    begin
      // RULE21: break forces space
      tx_line_q <= !break_ctl_q && (tx_busy_q ? tx_shift_q[0] : LINE_IDLE);
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 16'h0;
    end
    else if (!reg_rd)
    begin
      reg_rdata <= 16'h0;
    end
    else if (reg_addr == RX_STATUS_OFS)
    begin
      // RULE1: enable and done
      // RULE2: switch bits
      // RULE3: error bits
      reg_rdata <= {rx_error, rx_perr_q, rx_brk_q, rx_ovr_q, switch_bits,
                    rx_done_q, rx_ie_q, 6'h0};
    end
    else if (reg_addr == RX_BUFFER_OFS)
    begin
      reg_rdata <= {9'h0, rx_buf_q};
    end
    else if (reg_addr == TX_STATUS_OFS)
    begin
      // RULE17: enable and done
      // RULE18: modem ready, no interrupt
      reg_rdata <= {modem_ok, 3'h0, switch_bits, tx_done_q, tx_ie_q, 6'h0};
    end
    else
    begin
      reg_rdata <= 16'h0;
    end
  end

  // RULE7: receive interrupt
  // RULE16: level follows done and enable
  assign rx_int_req = rx_done_q && rx_ie_q;
  // RULE20: transmit interrupt
  assign tx_int_req = tx_done_q && tx_ie_q;
  assign serial_out = tx_line_q;
  assign reader_run = reader_run_q;

endmodule
`default_nettype wire

// ---- sps_serial_port_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module sps_serial_port_assertions
  import sps_pkg::*;
#(
  parameter int BAUD = DEFAULT_BAUD
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic bus_init,
  // Pins
  input wire logic serial_out,
  input wire logic reader_run,
  input wire logic [3:0] board_option_switches_on,
  input wire logic rx_int_req,
  input wire logic tx_int_req
);
  localparam int TX_MIN = 8 * (CLK_HZ / BAUD);
  localparam int TX_MAX = 12 * (CLK_HZ / BAUD);
  logic brk_q;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Software view of break control; init clears it
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      brk_q <= 1'b0;
    else if (bus_init)
      brk_q <= 1'b0;
    else if (reg_wr && reg_addr == TX_STATUS_OFS)
      brk_q <= reg_wdata[BREAK_CTL_BIT];
  end
  sequence s_rd_rx;
    reg_rd && reg_addr == RX_STATUS_OFS;
  endsequence
  sequence s_tx_frame;
    !tx_int_req [*8] ##[TX_MIN:TX_MAX] tx_int_req;
  endsequence
  sequence s_init_ie;
    bus_init ##1 (reg_wr && reg_addr == TX_STATUS_OFS && reg_wdata[IE_BIT]);
  endsequence
  property p_err_or;
    s_rd_rx |=> reg_rdata[ERROR_BIT] == |reg_rdata[PARITY_BIT:OVERRUN_BIT];
  endproperty
  a_err_or: assert property (p_err_or) else $error("summary bit");
  property p_switch;
    reg_rd && reg_addr[1:0] == 2'h0 |=> reg_rdata[11:8] == ~board_option_switches_on;
  endproperty
  a_switch: assert property (p_switch) else $error("switch bits");
  property p_rx_irq;
    s_rd_rx |=> (reg_rdata[DONE_BIT] & reg_rdata[IE_BIT]) == $past(rx_int_req);
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx request");
  property p_run;
    reg_wr && reg_addr == RX_STATUS_OFS && reg_wdata[READER_RUN_BIT] |=> reader_run;
  endproperty
  a_run: assert property (p_run) else $error("reader run");
  property p_brk;
    brk_q && $past(brk_q) |-> !serial_out;
  endproperty
  a_brk: assert property (p_brk) else $error("break hold");
  property p_tx_clr;
    reg_wr && reg_addr == TX_BUFFER_OFS |=> !tx_int_req;
  endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx done kept");
  property p_tx_frame;
    reg_wr && reg_addr == TX_BUFFER_OFS && tx_int_req |=> s_tx_frame;
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("tx frame time");
  property p_init;
    bus_init |=> !rx_int_req && !tx_int_req && !reader_run;
  endproperty
  a_init: assert property (p_init) else $error("init clear");
  property p_init_tx;
    s_init_ie |=> tx_int_req;
  endproperty
  a_init_tx: assert property (p_init_tx) else $error("init tx done");
endmodule
`default_nettype wire

// ---- sps_line_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module sps_line_partner
#(
  parameter int BITC = 10
)
(
  // Clock
  input wire logic clock,
  // Serial lines
  input wire logic txd,
  output logic rxd,
  // Decoded character
  output logic [7:0] got,
  output logic got_v
);
  logic [8:0] sh;
  initial
  begin
    rxd = 1'b1;
    got_v = 1'b0;
    got = 8'h00;
    forever
    begin
      @(negedge txd);
      repeat (BITC / 2) @(posedge clock);
      for (int i = 0; i < 9; i++)
      begin
        repeat (BITC) @(posedge clock);
        sh[i] = txd;
      end
      // Low stop bit means break, so no character
      if (sh[8])
      begin
        got <= sh[7:0];
        got_v <= 1'b1;
        @(posedge clock);
        got_v <= 1'b0;
      end
      wait (txd);
    end
  end
  // LSB first, then parity slot, then stop level
  task automatic send(input logic [8:0] f);
    @(posedge clock);
    rxd <= 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      repeat (BITC) @(posedge clock);
      rxd <= i < 9 ? f[i] : 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ---- test_sps_serial_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_sps_serial_port;
  import sps_pkg::*;
  localparam int BAUD = 12_500_000;
  localparam logic [2:0] EV [4] = '{3'h0, 3'h1, 3'h4, 3'h2};
  logic clock, rst_n, reg_wr, reg_rd, bus_init, serial_in, serial_out;
  logic reader_run, modem_ready, rx_int_req, tx_int_req, rd_d, got_v;
  logic seven_on, par_on;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0] sw;
  logic [6:0] d;
  logic [7:0] got;
  logic [31:0] rnd;
  logic [15:0] exp_q[$], ch_q[$];
  int err_count, tests_run;
  sps_serial_port #(.BAUD(BAUD)) u_sps_serial_port (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_init(bus_init), .serial_in(serial_in),
    .serial_out(serial_out), .reader_run(reader_run), .modem_ready(modem_ready),
    .board_option_switches_on(sw), .seven_bit_on(seven_on), .parity_on(par_on),
    .rx_int_req(rx_int_req), .tx_int_req(tx_int_req));
  sps_line_partner #(.BITC(CLK_HZ / BAUD)) u_sps_line_partner (.clock(clock),
    .txd(serial_out), .rxd(serial_in), .got(got), .got_v(got_v));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [15:0] rxs(input logic [2:0] e, input logic dn, ie);
    return {|e, e, ~sw, dn, ie, 6'h00};
  endfunction
  function automatic logic [15:0] txs(input logic dn, ie);
    return {modem_ready, 3'h0, ~sw, dn, ie, 6'h00};
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] g, e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic g, e);
    chk_word({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask
  // Bounded wait on a request line
  task automatic waitf(input logic tx);
    int n;
    n = 0;
    while ((tx ? tx_int_req : rx_int_req) !== 1'b1 && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    chk_pin(n < 400, 1'b1);
  endtask
  always @(posedge clock)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      chk_word(reg_rdata, exp_q.pop_front());
    if (got_v)
      chk_word({8'h00, got}, ch_q.size() > 0 ? ch_q.pop_front() : 16'hxxxx);
  end
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    finish_test();
  end
  initial
  begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, bus_init, modem_ready} = '0;
    {seven_on, par_on} = 2'b11;
    err_count = 0;
    tests_run = 0;
    rnd = lfsr(32'hf53f);
    sw = rnd[3:0];
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    // Pin inputs need two edges through the synchroniser
    repeat (2) @(posedge clock);
    rd(RX_STATUS_OFS, rxs(3'h0, 1'b0, 1'b0));
    rd(TX_STATUS_OFS, txs(1'b1, 1'b0));
    modem_ready <= 1'b1;
    rd(3'h1, 16'h0000);
    rd(TX_STATUS_OFS, txs(1'b1, 1'b0));
    wr(RX_STATUS_OFS, 16'h0040);
    wr(TX_STATUS_OFS, 16'h0040);
    @(negedge clock);
    chk_pin(rx_int_req, 1'b0);
    chk_pin(tx_int_req, 1'b1);
    rd(RX_STATUS_OFS, rxs(3'h0, 1'b0, 1'b1));
    rnd = lfsr(rnd);
    ch_q.push_back({9'h000, rnd[6:0]});
    wr(TX_BUFFER_OFS, rnd[15:0]);
    // Second load while shifting must be dropped
    wr(TX_BUFFER_OFS, 16'h0055);
    @(negedge clock);
    chk_pin(tx_int_req, 1'b0);
    waitf(1'b1);
    rd(TX_STATUS_OFS, txs(1'b1, 1'b1));
    wr(TX_STATUS_OFS, 16'h0041);
    // Long enough that the partner sees a low stop slot, not a character
    repeat (120) @(negedge clock);
    chk_pin(serial_out, 1'b0);
    wr(TX_STATUS_OFS, 16'h0040);
    repeat (3) @(negedge clock);
    chk_pin(serial_out, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      d = rnd[6:0];
      wr(RX_STATUS_OFS, 16'h0041);
      @(negedge clock);
      chk_pin(reader_run, 1'b1);
      if (k == 1)
        u_sps_line_partner.send({1'b1, ~^d, ~d});
      u_sps_line_partner.send(k == 3 ? 9'h000 : {1'b1, (^d) ^ (k == 2), d});
      waitf(1'b0);
      chk_pin(reader_run, 1'b0);
      rd(RX_STATUS_OFS, rxs(EV[k], 1'b1, 1'b1));
      rd(RX_BUFFER_OFS, k == 3 ? 16'h0000 : {9'h000, d});
      rd(RX_STATUS_OFS, rxs(3'h0, 1'b0, 1'b1));
    end
    // Eight data bits, no parity: bit 7 is sent as space and dropped on receipt, no parity check
    {seven_on, par_on} <= 2'b00;
    repeat (3) @(posedge clock);
    rnd = lfsr(rnd);
    d = rnd[6:0];
    ch_q.push_back({9'h000, d});
    wr(TX_BUFFER_OFS, rnd[15:0]);
    @(negedge clock);
    waitf(1'b1);
    u_sps_line_partner.send({1'b1, 1'b1, d});
    waitf(1'b0);
    rd(RX_STATUS_OFS, rxs(3'h0, 1'b1, 1'b1));
    rd(RX_BUFFER_OFS, {9'h000, d});
    u_sps_line_partner.send({1'b1, ^d, d});
    @(posedge clock);
    bus_init <= 1'b1;
    fork
      wr(TX_STATUS_OFS, 16'h0040);
      @(posedge clock) bus_init <= 1'b0;
    join
    rd(RX_STATUS_OFS, rxs(3'h0, 1'b0, 1'b0));
    rd(TX_STATUS_OFS, txs(1'b1, 1'b1));
    chk_word(16'(ch_q.size()), 16'h0000);
    finish_test();
  end
endmodule
bind sps_serial_port sps_serial_port_assertions #(.BAUD(BAUD)) u_chk (.*);
`default_nettype wire
